// ==== logic/arc_checker.v ====
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "arc_regs.vh"
// How it works
// - Extra-guard byte is an unsigned etu count added to spacing.
// - Guard 255 gives spacing 12 etus under protocol 0, 11 under protocol 1.
// - Guard 00h..FEh gives spacing of 12 plus the count.
// - Guard spacing only between consecutive terminal-sent characters.
// - Missing guard byte with format b7 clear acts as 00h.
// - First protocol byte: high nibble presence flags, low nibble protocol.
// - First protocol low nibble must be 0 or 1, flags consistent.
// - Mode byte present means specific mode, absent negotiable.
// - Mode byte needs b5 clear and supported parameters, else reject.
// - Any second-level programming-voltage byte causes rejection.
// - Work wait time is 960 times rate times integer, default 10.
// - Work wait byte 00h rejected, 0Ah accepted, others if supported.
// - Second protocol low nibble 1, or E after protocol 0, flags consistent.
// - Field size 00h..0Fh or FFh rejected; absent gives 20h.
// - Protocol-1 wait byte: low nibble char integer, high nibble block.
// - Reject missing wait byte, block over 4, char over 5, 2^char <= guard+1.
// - Guard 255 counts as minus one in that comparison.
// - Error-code byte must be 00h, meaning LRC.
// - Format byte high nibble flags the four first-level bytes.
// - Reject after cold reset asks warm reset, after warm deactivates.
module arc_checker (
	// Clock and reset
	input  wire        mclk,
	input  wire        arst_n,
	input  wire        clkEn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Received answer characters, after the initial character
	input  wire        rxValid,
	input  wire [7:0]  rxByte,
	input  wire        rxDone,
	// Rate factor and etu timing
	input  wire [3:0]  rateFactor,
	input  wire        etuTick,
	input  wire        txStart,
	output wire        txAllowed,
	// Verdict and session parameters
	output reg         doneOut,
	output reg         acceptOut,
	output reg         warmResetReq,
	output reg         deactivateReq,
	output reg  [8:0]  minSpacing,
	output reg         protoOne,
	output reg  [3:0]  charWaitInt,
	output reg  [3:0]  blockWaitInt,
	output reg  [7:0]  cardFieldSize,
	output reg  [7:0]  errorCodeType,
	output reg  [7:0]  workWaitInt,
	output reg  [15:0] workWaitTime,
	output reg         specificMode
);
	// ****************************************************************
	// Parser states
	// ****************************************************************
	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_FMT  = 3'd1;
	localparam [2:0] ST_L1   = 3'd2;
	localparam [2:0] ST_L2   = 3'd3;
	localparam [2:0] ST_L3   = 3'd4;
	localparam [2:0] ST_REST = 3'd5;
	localparam [2:0] ST_END  = 3'd6;

	reg  [2:0]  state_reg;
	reg  [3:0]  pend_reg;
	reg  [1:0]  idx_reg;
	reg  [3:0]  cause_reg;
	reg  [7:0]  guard_reg;
	reg  [3:0]  p1Nib_reg;
	reg         p1Seen_reg;
	reg         p2Seen_reg;
	reg         fsSeen_reg;
	reg         p1wSeen_reg;
	reg  [7:0]  fs_reg;
	reg  [7:0]  p1w_reg;
	reg  [7:0]  wwi_reg;
	reg  [7:0]  ect_reg;
	reg         mode_reg;
	reg         modeBad_reg;
	reg         warm_reg;
	reg  [2:0]  ctrl_reg;
	reg  [7:0]  support_reg;
	reg         done_reg;

	wire        apbWr = psel && penable && pwrite;
	wire        start = apbWr && (paddr == `ARC_OFF_CTRL) && pwdata[`ARC_CTRL_START];

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function [1:0] firstSet;
		input [3:0] m;
		begin
			firstSet = m[0] ? 2'd0 : m[1] ? 2'd1 : m[2] ? 2'd2 : 2'd3;
		end
	endfunction

	function [3:0] clearLow;
		input [3:0] m;
		begin
			clearLow = m & (m - 4'd1);
		end
	endfunction

	// 2^char <= guard+1, guard 255 taken as -1
	function charWaitTooSmall;
		input [3:0] cw;
		input [7:0] g;
		reg   [8:0] pw;
		begin
			pw = 9'd1 << cw[2:0];
			if (g == `ARC_GUARD_SPECIAL)
				charWaitTooSmall = 1'b0;
			else
				charWaitTooSmall = (pw <= ({1'b0, g} + 9'd1));
		end
	endfunction

	reg  [3:0]  cause_next;
	always @* begin
		cause_next = `ARC_CAUSE_NONE;
		if (state_reg == ST_L2) begin
			case (idx_reg)
				2'd0: cause_next = `ARC_CAUSE_MODE;
				2'd1: cause_next = `ARC_CAUSE_PROGV;
				2'd2: if (rxByte != `ARC_WWI_DEFAULT &&
					!(rxByte != 8'h00 && rxByte == support_reg))
					cause_next = `ARC_CAUSE_WWAIT;
				default: if (!(rxByte[3:0] == 4'h1 ||
					(rxByte[3:0] == 4'hE && p1Nib_reg == 4'h0)))
					cause_next = `ARC_CAUSE_PROTO2;
			endcase
			if (idx_reg == 2'd0 && !rxByte[4] && support_reg[0])
				cause_next = `ARC_CAUSE_NONE;
		end else if (state_reg == ST_L3) begin
			case (idx_reg)
				2'd0: if (rxByte < `ARC_FSIZE_MIN || rxByte == `ARC_FSIZE_BAD)
					cause_next = `ARC_CAUSE_FSIZE;
				2'd1: if (rxByte[7:4] > `ARC_BLKWAIT_MAX || rxByte[3:0] > `ARC_CHRWAIT_MAX ||
					charWaitTooSmall(rxByte[3:0], guard_reg))
					cause_next = `ARC_CAUSE_P1WAIT;
				2'd2: if (rxByte != `ARC_ECODE_LRC)
					cause_next = `ARC_CAUSE_ECODE;
				default: cause_next = `ARC_CAUSE_NONE;
			endcase
		end else if (state_reg == ST_L1 && idx_reg == 2'd3) begin
			if (rxByte[3:0] > 4'h1)
				cause_next = `ARC_CAUSE_PROTO1;
		end
	end

	// ****************************************************************
	// Parser
	// ****************************************************************
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg   <= ST_IDLE;
			pend_reg    <= 4'h0;
			idx_reg     <= 2'd0;
			cause_reg   <= `ARC_CAUSE_NONE;
			guard_reg   <= 8'h00;
			p1Nib_reg   <= 4'h0;
			p1Seen_reg  <= 1'b0;
			p2Seen_reg  <= 1'b0;
			fsSeen_reg  <= 1'b0;
			p1wSeen_reg <= 1'b0;
			fs_reg      <= `ARC_FSIZE_DEFAULT;
			p1w_reg     <= 8'h00;
			wwi_reg     <= `ARC_WWI_DEFAULT;
			ect_reg     <= `ARC_ECODE_LRC;
			mode_reg    <= 1'b0;
			modeBad_reg <= 1'b0;
			done_reg    <= 1'b0;
		end else if (clkEn) begin
			done_reg <= 1'b0;
			if (start) begin
				state_reg   <= ST_FMT;
				cause_reg   <= `ARC_CAUSE_NONE;
				guard_reg   <= 8'h00;
				p1Nib_reg   <= 4'h0;
				p1Seen_reg  <= 1'b0;
				p2Seen_reg  <= 1'b0;
				fsSeen_reg  <= 1'b0;
				p1wSeen_reg <= 1'b0;
				fs_reg      <= `ARC_FSIZE_DEFAULT;
				wwi_reg     <= `ARC_WWI_DEFAULT;
				ect_reg     <= `ARC_ECODE_LRC;
				mode_reg    <= 1'b0;
			end else begin
				case (state_reg)
					ST_FMT: if (rxValid) begin
						pend_reg  <= rxByte[7:4];
						idx_reg   <= firstSet(rxByte[7:4]);
						state_reg <= (rxByte[7:4] == 4'h0) ? ST_REST : ST_L1;
					end
					ST_L1, ST_L2, ST_L3: if (rxValid) begin
						if (cause_reg == `ARC_CAUSE_NONE)
							cause_reg <= cause_next;
						if (state_reg == ST_L1 && idx_reg == 2'd2)
							guard_reg <= rxByte;
						if (state_reg == ST_L2 && idx_reg == 2'd0)
							mode_reg <= 1'b1;
						if (state_reg == ST_L2 && idx_reg == 2'd2)
							wwi_reg <= rxByte;
						if (state_reg == ST_L3 && idx_reg == 2'd0) begin
							fs_reg     <= rxByte;
							fsSeen_reg <= 1'b1;
						end
						if (state_reg == ST_L3 && idx_reg == 2'd1) begin
							p1w_reg     <= rxByte;
							p1wSeen_reg <= 1'b1;
						end
						if (state_reg == ST_L3 && idx_reg == 2'd2)
							ect_reg <= rxByte;
						if (idx_reg == 2'd3 && state_reg != ST_L3) begin
							if (state_reg == ST_L1) begin
								p1Nib_reg  <= rxByte[3:0];
								p1Seen_reg <= 1'b1;
							end else begin
								p2Seen_reg <= (rxByte[3:0] == 4'h1);
							end
							pend_reg  <= rxByte[7:4];
							idx_reg   <= firstSet(rxByte[7:4]);
							state_reg <= (rxByte[7:4] == 4'h0) ? ST_REST :
								(state_reg == ST_L1 ? ST_L2 : ST_L3);
						end else if (clearLow(pend_reg) == 4'h0) begin
							state_reg <= ST_REST;
						end else begin
							pend_reg <= clearLow(pend_reg);
							idx_reg  <= firstSet(clearLow(pend_reg));
						end
					end
					ST_REST: if (rxDone) begin
						state_reg <= ST_END;
					end
					ST_END: begin
						// Protocol 1 needs its wait byte
						if (cause_reg == `ARC_CAUSE_NONE && p1Seen_reg &&
							(p1Nib_reg == 4'h1 || p2Seen_reg) && !p1wSeen_reg)
							cause_reg <= `ARC_CAUSE_P1WAIT;
						done_reg  <= 1'b1;
						state_reg <= ST_IDLE;
					end
					default: state_reg <= ST_IDLE;
				endcase
				// An rxDone that comes while announced bytes are still pending is a presence error
				if (rxDone && state_reg != ST_REST && state_reg != ST_IDLE &&
					state_reg != ST_END) begin
					if (cause_reg == `ARC_CAUSE_NONE)
						cause_reg <= `ARC_CAUSE_PRES;
					state_reg <= ST_END;
				end
			end
		end
	end

	// ****************************************************************
	// Verdict and session outputs
	// ****************************************************************
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			doneOut       <= 1'b0;
			acceptOut     <= 1'b0;
			warmResetReq  <= 1'b0;
			deactivateReq <= 1'b0;
			minSpacing    <= `ARC_BASE_SPACING;
			protoOne      <= 1'b0;
			charWaitInt   <= 4'h0;
			blockWaitInt  <= 4'h0;
			cardFieldSize <= `ARC_FSIZE_DEFAULT;
			errorCodeType <= `ARC_ECODE_LRC;
			workWaitInt   <= `ARC_WWI_DEFAULT;
			workWaitTime  <= 16'h0000;
			specificMode  <= 1'b0;
		end else if (clkEn) begin
			warmResetReq  <= 1'b0;
			deactivateReq <= 1'b0;
			if (start)
				doneOut <= 1'b0;
			if (done_reg) begin
				doneOut      <= 1'b1;
				acceptOut    <= (cause_reg == `ARC_CAUSE_NONE);
				warmResetReq  <= (cause_reg != `ARC_CAUSE_NONE) && !warm_reg;
				deactivateReq <= (cause_reg != `ARC_CAUSE_NONE) && warm_reg;
				protoOne     <= (p1Nib_reg == 4'h1);
				if (guard_reg == `ARC_GUARD_SPECIAL)
					minSpacing <= (p1Nib_reg == 4'h1) ? `ARC_T1_SPACING :
						`ARC_BASE_SPACING;
				else
					minSpacing <= `ARC_BASE_SPACING + {1'b0, guard_reg};
				charWaitInt   <= p1w_reg[3:0];
				blockWaitInt  <= p1w_reg[7:4];
				cardFieldSize <= fs_reg;
				errorCodeType <= ect_reg;
				workWaitInt   <= wwi_reg;
				workWaitTime  <= `ARC_WORK_FACTOR * {12'h000, rateFactor} *
					{8'h00, wwi_reg};
				specificMode  <= mode_reg;
			end
		end
	end

	// ****************************************************************
	// APB registers
	// ****************************************************************
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg    <= 3'b000;
			warm_reg    <= 1'b0;
			support_reg <= 8'h00;
		end else if (clkEn && apbWr) begin
			if (paddr == `ARC_OFF_CTRL) begin
				ctrl_reg <= pwdata[2:0];
				if (pwdata[`ARC_CTRL_START])
					warm_reg <= pwdata[`ARC_CTRL_WARM];
			end
			if (paddr == `ARC_OFF_SUPPORT)
				support_reg <= pwdata[7:0];
		end
	end

	always @* begin
		case (paddr)
			`ARC_OFF_CTRL:    prdata = {29'h0, ctrl_reg[2:1], 1'b0};
			`ARC_OFF_STATUS:  prdata = {20'h0, cause_reg, 4'h0, 1'b0,
				state_reg == ST_IDLE, acceptOut, doneOut};
			`ARC_OFF_GUARD:   prdata = {15'h0, minSpacing, guard_reg};
			`ARC_OFF_PARAMS:  prdata = {3'h0, specificMode, 3'h0, protoOne,
				errorCodeType, cardFieldSize, blockWaitInt, charWaitInt};
			`ARC_OFF_WORKWAIT: prdata = {8'h00, workWaitInt, workWaitTime};
			`ARC_OFF_SUPPORT: prdata = {24'h0, support_reg};
			default:          prdata = 32'h0000_0000;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && (paddr > `ARC_OFF_SUPPORT || paddr[1:0] != 2'b00);

	arc_spacer u_spacer (
		.mclk       (mclk),
		.arst_n     (arst_n),
		.clkEn      (clkEn),
		.etuTick    (etuTick),
		.minSpacing (minSpacing),
		.txStart    (txStart),
		.rxStart    (rxValid),
		.txAllowed  (txAllowed)
	);
endmodule // arc_checker

// ==== logic/arc_regs.vh ====
`ifndef ARC_REGS_VH
`define ARC_REGS_VH
// ****************************************************************
// APB register map (byte addresses)
// ****************************************************************
`define ARC_OFF_CTRL      12'h000
`define ARC_OFF_STATUS    12'h004
`define ARC_OFF_GUARD     12'h008
`define ARC_OFF_PARAMS    12'h00C
`define ARC_OFF_WORKWAIT  12'h010
`define ARC_OFF_SUPPORT   12'h014
// ****************************************************************
// Control fields
// ****************************************************************
`define ARC_CTRL_START    0
`define ARC_CTRL_WARM     1
`define ARC_CTRL_T0EN     2
// ****************************************************************
// Reject causes
// ****************************************************************
`define ARC_CAUSE_NONE    4'h0
`define ARC_CAUSE_PROTO1  4'h1
`define ARC_CAUSE_MODE    4'h2
`define ARC_CAUSE_PROGV   4'h3
`define ARC_CAUSE_WWAIT   4'h4
`define ARC_CAUSE_PROTO2  4'h5
`define ARC_CAUSE_FSIZE   4'h6
`define ARC_CAUSE_P1WAIT  4'h7
`define ARC_CAUSE_ECODE   4'h8
`define ARC_CAUSE_PRES    4'h9
// ****************************************************************
// Defaults and limits
// ****************************************************************
`define ARC_GUARD_SPECIAL 8'hFF
`define ARC_BASE_SPACING  9'd12
`define ARC_T1_SPACING    9'd11
`define ARC_WWI_DEFAULT   8'h0A
`define ARC_WORK_FACTOR   16'd960
`define ARC_FSIZE_DEFAULT 8'h20
`define ARC_FSIZE_MIN     8'h10
`define ARC_FSIZE_BAD     8'hFF
`define ARC_BLKWAIT_MAX   4'h4
`define ARC_CHRWAIT_MAX   4'h5
`define ARC_ECODE_LRC     8'h00
`endif

// ==== logic/arc_spacer.v ====
`timescale 1ns/1ps
// ****************************************************************
// Terminal-to-card character spacing gate
// ****************************************************************
module arc_spacer (
	// Clock and reset
	input  wire       mclk,
	input  wire       arst_n,
	input  wire       clkEn,
	// Timing
	input  wire       etuTick,
	input  wire [8:0] minSpacing,
	// Transmit side
	input  wire       txStart,
	input  wire       rxStart,
	output wire       txAllowed
);
	reg  [8:0] count_reg;
	reg        armed_reg;

	// Only back-to-back transmit characters are gated; a receive resets it
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= 9'd0;
			armed_reg <= 1'b0;
		end else if (clkEn) begin
			if (rxStart) begin
				armed_reg <= 1'b0;
			end else if (txStart) begin
				armed_reg <= 1'b1;
				count_reg <= 9'd0;
			end else if (armed_reg && etuTick && count_reg != 9'h1FF) begin
				count_reg <= count_reg + 9'd1;
			end
		end
	end

	assign txAllowed = !armed_reg || (count_reg >= minSpacing);
endmodule // arc_spacer

// ==== verification/arc_card_model.sv ====
`timescale 1ns/1ps
module arc_card_model (
	// Clock
	input wire logic  mclk,
	// Answer characters
	output logic       rxValid,
	output logic [7:0] rxByte,
	output logic       rxDone
);
	initial begin
		rxValid = 1'b0;
		rxByte = 8'h00;
		rxDone = 1'b0;
	end
	// Idle byte lines show the inverse so stale data never passes
	task sendByte(input logic [7:0] v);
		@(posedge mclk);
		rxValid <= 1'b1;
		rxByte <= v;
		@(posedge mclk);
		rxValid <= 1'b0;
		rxByte <= ~v;
		repeat (2) @(posedge mclk);
	endtask
	task sendAtr(input logic [7:0] b[$]);
		foreach (b[i]) sendByte(b[i]);
		@(posedge mclk);
		rxDone <= 1'b1;
		@(posedge mclk);
		rxDone <= 1'b0;
	endtask
endmodule // arc_card_model

// ==== verification/arc_checker_asserts.sv ====
`timescale 1ns/1ps
module arc_checker_asserts (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       arst_n,
	// Stimulus seen
	input wire logic       rxDone,
	input wire logic       rxValid,
	input wire logic       txStart,
	// Design outputs
	input wire logic       txAllowed,
	input wire logic       doneOut,
	input wire logic       acceptOut,
	input wire logic       warmResetReq,
	input wire logic       deactivateReq,
	input wire logic [8:0] minSpacing,
	input wire logic       protoOne,
	input wire logic [3:0] charWaitInt,
	input wire logic [3:0] blockWaitInt,
	input wire logic [7:0] cardFieldSize,
	input wire logic [7:0] errorCodeType,
	input wire logic [7:0] workWaitInt
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ****************************************************************
	// Verdict and session parameters
	// ****************************************************************
	property p_warm;
		warmResetReq |-> $rose(doneOut) && !acceptOut;
	endproperty
	a_warm: assert property (p_warm) else $error("warm request without reject");
	property p_deact;
		deactivateReq |-> $rose(doneOut) && !acceptOut && !warmResetReq;
	endproperty
	a_deact: assert property (p_deact) else $error("deactivate without reject");
	property p_done;
		rxDone |-> ##[1:3] $rose(doneOut);
	endproperty
	a_done: assert property (p_done) else $error("verdict late");
	property p_spacing;
		minSpacing inside {[9'h00B:9'h10A]};
	endproperty
	a_spacing: assert property (p_spacing) else $error("spacing out of range");
	property p_t1sp;
		doneOut && acceptOut && minSpacing == 9'h00B |-> protoOne;
	endproperty
	a_t1sp: assert property (p_t1sp) else $error("spacing 11 without protocol 1");
	property p_tx;
		txStart && !rxValid |=> !txAllowed;
	endproperty
	a_tx: assert property (p_tx) else $error("send allowed right after send");
	// Bad values never survive an accepted answer
	property p_fs;
		doneOut && acceptOut |-> cardFieldSize inside {[8'h10:8'hFE]};
	endproperty
	a_fs: assert property (p_fs) else $error("field size accepted badly");
	property p_wait;
		doneOut && acceptOut && protoOne |-> blockWaitInt <= 4'h4 && charWaitInt <= 4'h5;
	endproperty
	a_wait: assert property (p_wait) else $error("wait integers accepted badly");
	property p_ec;
		doneOut && acceptOut |-> errorCodeType == 8'h00;
	endproperty
	a_ec: assert property (p_ec) else $error("error code accepted badly");
	property p_wi;
		doneOut && acceptOut |-> workWaitInt != 8'h00;
	endproperty
	a_wi: assert property (p_wi) else $error("zero work wait accepted");
endmodule // arc_checker_asserts

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        mclk, arst_n, clkEn, psel, penable, pwrite, txStart, etuTick, slvErr;
	logic        pready, pslverr, rxValid, rxDone, txAllowed, doneOut, acceptOut;
	logic        warmResetReq, deactivateReq, protoOne, specificMode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  rateFactor, charWaitInt, blockWaitInt;
	logic [1:0]  etuCnt;
	logic [7:0]  rxByte, cardFieldSize, errorCodeType, workWaitInt;
	logic [8:0]  minSpacing;
	logic [15:0] workWaitTime;
	int          err_count, n_tests;
	arc_checker arc_checker_inst (.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxValid(rxValid), .rxByte(rxByte),
		.rxDone(rxDone), .rateFactor(rateFactor), .etuTick(etuTick), .txStart(txStart),
		.txAllowed(txAllowed), .doneOut(doneOut), .acceptOut(acceptOut),
		.warmResetReq(warmResetReq), .deactivateReq(deactivateReq), .minSpacing(minSpacing),
		.protoOne(protoOne), .charWaitInt(charWaitInt), .blockWaitInt(blockWaitInt),
		.cardFieldSize(cardFieldSize), .errorCodeType(errorCodeType),
		.workWaitInt(workWaitInt), .workWaitTime(workWaitTime), .specificMode(specificMode));
	arc_card_model arc_card_model_inst (.mclk(mclk), .rxValid(rxValid), .rxByte(rxByte),
		.rxDone(rxDone));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// One etu every four clocks keeps spacing runs short
	always @(posedge mclk) begin
		if (!arst_n) begin
			etuCnt <= 2'h0;
			etuTick <= 1'b0;
		end else begin
			etuCnt <= etuCnt + 2'h1;
			etuTick <= (etuCnt == 2'h3);
		end
	end
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		d = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task runAtr(input logic [7:0] b[$], input logic warm, input logic acc, input logic [3:0] c);
		logic [31:0] d;
		logic        pulse;
		int          i;
		apb(1'b1, 12'h000, warm ? 32'h0000_0003 : 32'h0000_0001, d);
		arc_card_model_inst.sendAtr(b);
		i = 0;
		while (doneOut !== 1'b1 && i < 20) begin
			@(posedge mclk);
			#1;
			i++;
		end
		pulse = warm ? deactivateReq : warmResetReq;
		chk(doneOut === 1'b1 && acceptOut === acc, "verdict");
		chk(pulse === !acc, "reset request pulse");
		apb(1'b0, 12'h004, 32'h0000_0000, d);
		chk(d[11:8] === c && d[1] === acc, "status cause");
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task testReset;
		logic [31:0] d;
		apb(1'b0, 12'h004, 32'h0000_0000, d);
		chk(d[2:0] === 3'h4 && d[11:8] === 4'h0, "status after reset");
		apb(1'b0, 12'h008, 32'h0000_0000, d);
		chk(d[16:8] === 9'h00C && cardFieldSize === 8'h20, "guard after reset");
		apb(1'b0, 12'h020, 32'h0000_0000, d);
		chk(d === 32'h0000_0000 && slvErr === 1'b1, "unmapped read");
		$display("test reset done");
	endtask
	task testGuard;
		logic [31:0] d;
		runAtr({8'h60, 8'h00, 8'h05}, 1'b0, 1'b1, 4'h0);
		chk(minSpacing === 9'h011 && protoOne === 1'b0, "guard 5 spacing");
		chk(workWaitInt === 8'h0A && workWaitTime === 16'h4B00, "default work wait");
		chk(specificMode === 1'b0, "negotiable mode");
		apb(1'b0, 12'h008, 32'h0000_0000, d);
		chk(d[16:8] === 9'h011 && d[7:0] === 8'h05, "guard register");
		// Frozen enable must swallow a start
		clkEn <= 1'b0;
		apb(1'b1, 12'h000, 32'h0000_0001, d);
		apb(1'b0, 12'h004, 32'h0000_0000, d);
		clkEn <= 1'b1;
		chk(d[2:0] === 3'h7, "start ignored while frozen");
		$display("test guard done");
	endtask
	task testSpacing;
		int c;
		@(posedge mclk);
		txStart <= 1'b1;
		@(posedge mclk);
		txStart <= 1'b0;
		#1;
		c = 0;
		while (txAllowed !== 1'b1 && c < 400) begin
			@(posedge mclk);
			#1;
			c++;
		end
		chk(c >= 64 && c <= 72, "send spacing 17 etus");
		@(posedge mclk);
		txStart <= 1'b1;
		@(posedge mclk);
		txStart <= 1'b0;
		arc_card_model_inst.sendByte(8'h55);
		chk(txAllowed === 1'b1, "opposite direction free");
		$display("test spacing done");
	endtask
	task testT1;
		runAtr({8'hE0, 8'h00, 8'hFF, 8'h81, 8'h31, 8'hFE, 8'h45}, 1'b0, 1'b1, 4'h0);
		chk(minSpacing === 9'h00B && protoOne === 1'b1, "t1 spacing");
		chk(charWaitInt === 4'h5 && blockWaitInt === 4'h4, "wait integers");
		chk(cardFieldSize === 8'hFE && errorCodeType === 8'h00, "t1 params");
		runAtr({8'h20, 8'h00}, 1'b0, 1'b1, 4'h0);
		chk(minSpacing === 9'h00C, "absent guard");
		runAtr({8'h40, 8'hFF}, 1'b0, 1'b1, 4'h0);
		chk(minSpacing === 9'h00C, "guard 255 under t0");
		$display("test t1 done");
	endtask
	task testProto1;
		runAtr({8'h80, 8'h02}, 1'b0, 1'b0, 4'h1);
		runAtr({8'h80, 8'h10}, 1'b1, 1'b0, 4'h9);
		runAtr({8'h80, 8'h00}, 1'b1, 1'b1, 4'h0);
		$display("test proto1 done");
	endtask
	task testMode;
		logic [31:0] d;
		apb(1'b1, 12'h014, 32'h0000_0001, d);
		runAtr({8'h80, 8'h10, 8'h10}, 1'b0, 1'b0, 4'h2);
		runAtr({8'h80, 8'h10, 8'h00}, 1'b0, 1'b1, 4'h0);
		chk(specificMode === 1'b1, "specific mode");
		apb(1'b1, 12'h014, 32'h0000_0000, d);
		runAtr({8'h80, 8'h10, 8'h00}, 1'b0, 1'b0, 4'h2);
		runAtr({8'h80, 8'h20, 8'h00}, 1'b0, 1'b0, 4'h3);
		runAtr({8'h80, 8'h30, 8'h10, 8'h00}, 1'b0, 1'b0, 4'h2);
		$display("test mode done");
	endtask
	task testWorkWait;
		logic [31:0] d;
		runAtr({8'h80, 8'h40, 8'h00}, 1'b0, 1'b0, 4'h4);
		runAtr({8'h80, 8'h40, 8'h05}, 1'b0, 1'b0, 4'h4);
		runAtr({8'h80, 8'h40, 8'h0A}, 1'b0, 1'b1, 4'h0);
		apb(1'b1, 12'h014, 32'h0000_0005, d);
		runAtr({8'h80, 8'h40, 8'h05}, 1'b0, 1'b1, 4'h0);
		chk(workWaitInt === 8'h05 && workWaitTime === 16'h2580, "supported work wait");
		$display("test work wait done");
	endtask
	task testProto2;
		runAtr({8'h80, 8'h81, 8'h02}, 1'b0, 1'b0, 4'h5);
		runAtr({8'h80, 8'h81, 8'h0E}, 1'b0, 1'b0, 4'h5);
		runAtr({8'h80, 8'h80, 8'h0E}, 1'b0, 1'b1, 4'h0);
		$display("test proto2 done");
	endtask
	task testT1Bytes;
		runAtr({8'h80, 8'h81, 8'h31, 8'h0F, 8'h45}, 1'b0, 1'b0, 4'h6);
		runAtr({8'h80, 8'h81, 8'h31, 8'hFF, 8'h45}, 1'b0, 1'b0, 4'h6);
		runAtr({8'h80, 8'h81, 8'h21, 8'h45}, 1'b0, 1'b1, 4'h0);
		chk(cardFieldSize === 8'h20, "default field size");
		runAtr({8'h80, 8'h81, 8'h11, 8'h20}, 1'b0, 1'b0, 4'h7);
		runAtr({8'h80, 8'h81, 8'h21, 8'h55}, 1'b0, 1'b0, 4'h7);
		runAtr({8'h80, 8'h81, 8'h21, 8'h46}, 1'b0, 1'b0, 4'h7);
		runAtr({8'hC0, 8'h1F, 8'h81, 8'h21, 8'h45}, 1'b0, 1'b0, 4'h7);
		runAtr({8'hC0, 8'h1E, 8'h81, 8'h21, 8'h45}, 1'b0, 1'b1, 4'h0);
		chk(minSpacing === 9'h02A, "guard 30 spacing");
		runAtr({8'h80, 8'h81, 8'h61, 8'h45, 8'h01}, 1'b0, 1'b0, 4'h8);
		runAtr({8'h80, 8'h81, 8'h61, 8'h45, 8'h00}, 1'b0, 1'b1, 4'h0);
		$display("test t1 bytes done");
	endtask
	task finish_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		{arst_n, psel, penable, pwrite, txStart} = 5'h00;
		{paddr, pwdata} = 44'h000_0000_0000;
		clkEn = 1'b1;
		rateFactor = 4'h2;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		testReset;
		testGuard;
		testSpacing;
		testT1;
		testProto1;
		testMode;
		testWorkWait;
		testProto2;
		testT1Bytes;
		finish_test;
	end
	initial begin
		#2_000_000;
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		finish_test;
	end
endmodule // tb_top
bind arc_checker arc_checker_asserts arc_checker_asserts_inst (.mclk(mclk), .arst_n(arst_n),
	.rxDone(rxDone), .rxValid(rxValid), .txStart(txStart), .txAllowed(txAllowed),
	.doneOut(doneOut), .acceptOut(acceptOut), .warmResetReq(warmResetReq),
	.deactivateReq(deactivateReq), .minSpacing(minSpacing), .protoOne(protoOne),
	.charWaitInt(charWaitInt), .blockWaitInt(blockWaitInt), .cardFieldSize(cardFieldSize),
	.errorCodeType(errorCodeType), .workWaitInt(workWaitInt));
